/* light_cfg.svh */
// Register offsets, reset values and timing counts for the light readout block
`ifndef LIGHT_CFG_SVH
`define LIGHT_CFG_SVH

// Register byte offsets
`define OFS_CONFIG   8'h00
`define OFS_TH_HIGH  8'h04
`define OFS_TH_LOW   8'h08
`define OFS_FLAGS    8'h0C
`define OFS_RES_VIS  8'h10
`define OFS_RES_WB   8'h14
`define OFS_LIN_VIS  8'h18
`define OFS_LIN_WB   8'h1C

// Field positions in the flag register
`define FLAG_HIGH_BIT 0
`define FLAG_LOW_BIT  1

// Reset values: automatic range, 100 ms conversion, idle
`define CONFIG_RESET 32'h0000_008C
`define TH_HIGH_RESET 32'h0000_FFFF
`define TH_LOW_RESET  32'h0000_0000

// Range codes and limits
`define RANGE_AUTO  4'hC
`define TOP_VIS     4'h8
`define TOP_WB      4'h6
`define CONV_MAX    4'hB

// Auto-range decision points on the 20-bit value
`define LOW2_LIMIT  20'h2_0000
`define LOW1_LIMIT  20'h4_0000
`define HIGH_LIMIT  20'hE_0000

// Bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// Conversion times in microseconds and cycles at the bus clock
`define CLK_MHZ     200
`define CONV_US_0   600
`define CONV_US_1   1000
`define CONV_US_2   1800
`define CONV_US_3   3400
`define CONV_US_4   6500
`define CONV_US_5   12700
`define CONV_US_6   25000
`define CONV_US_7   50000
`define CONV_US_8   100000
`define CONV_US_9   200000
`define CONV_US_10  400000
`define CONV_US_11  800000
`define CONV_CYC(us) ((us) * `CLK_MHZ)

`endif

/* light_pkg.sv */
// Types shared by the light readout block
package light_pkg;

  typedef struct packed {
    logic        over;
    logic [19:0] value;
  } sample_s;

  typedef struct packed {
    logic [11:0] upper;
    logic [7:0]  lower;
    logic [7:0]  zero;
    logic [3:0]  shift;
  } result_s;

  typedef struct packed {
    logic [19:0] zero;
    logic        enable;
    logic [1:0]  fault_count;
    logic        latch;
    logic [3:0]  conv;
    logic [3:0]  range;
  } cfg_s;

  typedef struct packed {
    logic [15:0] zero;
    logic [3:0]  shift;
    logic [11:0] value;
  } thresh_s;

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} meas_e;

endpackage

/* range_step.sv */
// Next full-scale range choice for one channel
`include "light_cfg.svh"

module range_step
  import light_pkg::*;
(
  input  wire logic    auto_mode,
  input  wire logic [3:0] manual,
  input  wire logic [3:0] top,
  input  wire logic [3:0] cur,
  input  wire sample_s smp,
  output logic [3:0]   next_range,
  output logic         retry
);

  // Manual clamp, overflow retry, or step up or down
  always_comb
  begin
    retry      = 1'b0;
    next_range = cur;
    if (!auto_mode)
      next_range = (manual > top) ? top : manual;
    else if (smp.over)
    begin
      if (cur < top)
      begin
        retry      = 1'b1;
        next_range = cur + 4'h1;
      end
    end
    else if (smp.value >= `HIGH_LIMIT && cur < top)
      next_range = cur + 4'h1;
    else if (smp.value < `LOW2_LIMIT)
      next_range = (cur >= 4'h2) ? cur - 4'h2 : 4'h0;
    else if (smp.value < `LOW1_LIMIT && cur != 4'h0)
      next_range = cur - 4'h1;
  end

endmodule // range_step

/* light_autorange_result_threshold.sv */
// Range control, result packing and threshold flags with an AXI4-Lite slave
`include "light_cfg.svh"

module light_autorange_result_threshold
  import light_pkg::*;
#(
  parameter int unsigned conv_cycles [12] = '{
    `CONV_CYC(`CONV_US_0), `CONV_CYC(`CONV_US_1), `CONV_CYC(`CONV_US_2),
    `CONV_CYC(`CONV_US_3), `CONV_CYC(`CONV_US_4), `CONV_CYC(`CONV_US_5),
    `CONV_CYC(`CONV_US_6), `CONV_CYC(`CONV_US_7), `CONV_CYC(`CONV_US_8),
    `CONV_CYC(`CONV_US_9), `CONV_CYC(`CONV_US_10), `CONV_CYC(`CONV_US_11)}
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire sample_s     fe_vis,
  input  wire sample_s     fe_wb,
  output logic             fe_start,
  output logic [3:0]       fe_range_vis,
  output logic [3:0]       fe_range_wb
);

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return a == `OFS_CONFIG || a == `OFS_TH_HIGH || a == `OFS_TH_LOW ||
           a == `OFS_FLAGS || a == `OFS_RES_VIS || a == `OFS_RES_WB ||
           a == `OFS_LIN_VIS || a == `OFS_LIN_WB;
  endfunction

  function automatic logic [27:0] lin_code(logic [19:0] v, logic [3:0] s);
    return {8'h00, v} << s;
  endfunction

  function automatic logic [35:0] th_code(thresh_s t);
    return 36'(t.value) << (5'(t.shift) + 5'h08);
  endfunction

  function automatic logic [3:0] fault_need(logic [1:0] fc);
    return 4'h1 << fc;
  endfunction

  function automatic logic [3:0] conv_idx(logic [3:0] c);
    return (c > `CONV_MAX) ? `CONV_MAX : c;
  endfunction

  // State
  cfg_s        cfg, next_cfg;
  thresh_s     th_h, next_th_h, th_l, next_th_l;
  logic        aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0]  wr_strb, next_wr_strb;
  logic        next_awready, next_wready, next_bvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic        next_arready, next_rvalid;
  logic [31:0] next_rdata;
  meas_e       state, next_state;
  logic [27:0] cnt, next_cnt, lim, next_lim;
  logic        next_start, report, next_report;
  logic [3:0]  next_rv, next_rw;
  result_s     res_vis, next_res_vis, res_wb, next_res_wb;
  logic [27:0] lin_vis, next_lin_vis, lin_wb, next_lin_wb;
  logic [3:0]  hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
  logic        flag_h, next_flag_h, flag_l, next_flag_l;

  // Shared decodes
  logic        auto_mode, wr_fire, rd_flags, conv_end, rep_now;
  logic        rt_vis, rt_wb, retry_any, hi_now, lo_now, hi_q, lo_q;
  logic [3:0]  nr_vis, nr_wb, need;
  logic [27:0] lin_now;

  assign auto_mode = (cfg.range == `RANGE_AUTO);
  assign wr_fire   = aw_full && w_full && !bvalid;
  assign rd_flags  = arvalid && arready && araddr == `OFS_FLAGS;
  assign conv_end  = (state == ST_CONV) && cnt >= lim;
  assign retry_any = rt_vis || rt_wb;
  assign rep_now   = conv_end && !retry_any;
  assign lin_now   = lin_code(fe_vis.value, fe_range_vis);
  assign hi_now    = 36'(lin_now) > th_code(th_h);
  assign lo_now    = 36'(lin_now) < th_code(th_l);
  assign need      = fault_need(cfg.fault_count);
  assign hi_q      = hi_now && (hi_cnt + 4'h1 >= need);
  assign lo_q      = lo_now && (lo_cnt + 4'h1 >= need);

  // Each channel steers its own range
  range_step u_step_vis (
    .auto_mode  (auto_mode),
    .manual     (cfg.range),
    .top        (`TOP_VIS),
    .cur        (fe_range_vis),
    .smp        (fe_vis),
    .next_range (nr_vis),
    .retry      (rt_vis)
  );

  range_step u_step_wb (
    .auto_mode  (auto_mode),
    .manual     (cfg.range),
    .top        (`TOP_WB),
    .cur        (fe_range_wb),
    .smp        (fe_wb),
    .next_range (nr_wb),
    .retry      (rt_wb)
  );

  // Write channel: address and data taken in either order
  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (awvalid && awready)
    begin
      next_aw_full = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_full  = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  // Read channel: one cycle answer
  always_comb
  begin
    next_rvalid = rvalid && !rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr)
        `OFS_CONFIG:  next_rdata = cfg;
        `OFS_TH_HIGH: next_rdata = th_h;
        `OFS_TH_LOW:  next_rdata = th_l;
        `OFS_FLAGS:   next_rdata = {30'h0000_0000, flag_l, flag_h};
        `OFS_RES_VIS: next_rdata = res_vis;
        `OFS_RES_WB:  next_rdata = res_wb;
        `OFS_LIN_VIS: next_rdata = {4'h0, lin_vis};
        `OFS_LIN_WB:  next_rdata = {4'h0, lin_wb};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Software registers
  always_comb
  begin
    next_cfg  = cfg;
    next_th_h = th_h;
    next_th_l = th_l;
    if (wr_fire && wr_addr == `OFS_CONFIG)
      next_cfg = merge(cfg, wr_data, wr_strb);
    if (wr_fire && wr_addr == `OFS_TH_HIGH)
      next_th_h = merge(th_h, wr_data, wr_strb);
    if (wr_fire && wr_addr == `OFS_TH_LOW)
      next_th_l = merge(th_l, wr_data, wr_strb);
    next_cfg.zero  = '0;
    next_th_h.zero = '0;
    next_th_l.zero = '0;
  end

  // Measurement sequencing
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_lim     = lim;
    next_start   = 1'b0;
    next_report  = 1'b0;
    next_rv      = fe_range_vis;
    next_rw      = fe_range_wb;
    next_res_vis = res_vis;
    next_res_wb  = res_wb;
    next_lin_vis = lin_vis;
    next_lin_wb  = lin_wb;
    case (state)
      ST_IDLE:
        if (cfg.enable)
        begin
          next_state = ST_CONV;
          next_start = 1'b1;
          next_cnt   = 28'h000_0000;
          next_lim   = 28'(conv_cycles[conv_idx(cfg.conv)] - 1);
          next_rv    = auto_mode ? fe_range_vis : nr_vis;
          next_rw    = auto_mode ? fe_range_wb : nr_wb;
        end
      ST_CONV:
        if (conv_end && retry_any)
        begin
          next_start = 1'b1;
          next_cnt   = 28'h000_0000;
          next_rv    = rt_vis ? nr_vis : fe_range_vis;
          next_rw    = rt_wb ? nr_wb : fe_range_wb;
        end
        else if (conv_end)
        begin
          next_report  = 1'b1;
          next_res_vis = {fe_vis.value, 8'h00, fe_range_vis};
          next_res_wb  = {fe_wb.value, 8'h00, fe_range_wb};
          next_lin_vis = lin_now;
          next_lin_wb  = lin_code(fe_wb.value, fe_range_wb);
          next_rv      = nr_vis;
          next_rw      = nr_wb;
          next_cnt     = 28'h000_0000;
          next_lim     = 28'(conv_cycles[conv_idx(cfg.conv)] - 1);
          next_start   = cfg.enable;
          next_state   = cfg.enable ? ST_CONV : ST_IDLE;
        end
        else
          next_cnt = cnt + 28'h000_0001;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Fault runs and flags
  always_comb
  begin
    next_hi_cnt = hi_cnt;
    next_lo_cnt = lo_cnt;
    next_flag_h = flag_h;
    next_flag_l = flag_l;
    if (rd_flags && cfg.latch)
    begin
      next_flag_h = 1'b0;
      next_flag_l = 1'b0;
    end
    if (rep_now)
    begin
      next_hi_cnt = hi_now ? (hi_q ? need : hi_cnt + 4'h1) : 4'h0;
      next_lo_cnt = lo_now ? (lo_q ? need : lo_cnt + 4'h1) : 4'h0;
      if (cfg.latch)
      begin
        if (hi_q)
          next_flag_h = 1'b1;
        if (lo_q)
          next_flag_l = 1'b1;
      end
      else if (hi_q)
      begin
        next_flag_h = 1'b1;
        next_flag_l = 1'b0;
      end
      else if (lo_q)
      begin
        next_flag_h = 1'b0;
        next_flag_l = 1'b1;
      end
    end
  end

  // Registers of every group
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0; w_full <= 1'b0; awready <= 1'b0; wready <= 1'b0;
      wr_addr <= 8'h00; wr_data <= 32'h0000_0000; wr_strb <= 4'h0;
      bvalid <= 1'b0; bresp <= `RESP_OKAY;
      arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
      cfg <= `CONFIG_RESET; th_h <= `TH_HIGH_RESET; th_l <= `TH_LOW_RESET;
      state <= ST_IDLE; cnt <= 28'h000_0000; lim <= 28'h000_0000;
      fe_start <= 1'b0; report <= 1'b0;
      fe_range_vis <= 4'h0; fe_range_wb <= 4'h0;
      res_vis <= '0; res_wb <= '0;
      lin_vis <= 28'h000_0000; lin_wb <= 28'h000_0000;
      hi_cnt <= 4'h0; lo_cnt <= 4'h0; flag_h <= 1'b0; flag_l <= 1'b0;
    end
    else
    begin
      aw_full <= next_aw_full; w_full <= next_w_full;
      awready <= next_awready; wready <= next_wready;
      wr_addr <= next_wr_addr; wr_data <= next_wr_data; wr_strb <= next_wr_strb;
      bvalid <= next_bvalid; bresp <= next_bresp;
      arready <= next_arready; rvalid <= next_rvalid;
      rdata <= next_rdata; rresp <= next_rresp;
      cfg <= next_cfg; th_h <= next_th_h; th_l <= next_th_l;
      state <= next_state; cnt <= next_cnt; lim <= next_lim;
      fe_start <= next_start; report <= next_report;
      fe_range_vis <= next_rv; fe_range_wb <= next_rw;
      res_vis <= next_res_vis; res_wb <= next_res_wb;
      lin_vis <= next_lin_vis; lin_wb <= next_lin_wb;
      hi_cnt <= next_hi_cnt; lo_cnt <= next_lo_cnt;
      flag_h <= next_flag_h; flag_l <= next_flag_l;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] man_rng;
  assign man_rng = cfg.range;

  a_manual_vis_range:
    assert property (fe_start && !$past(auto_mode) |->
      fe_range_vis == (($past(man_rng) > `TOP_VIS) ? `TOP_VIS : $past(man_rng)))
    else $error("manual visible range wrong");
  a_manual_wb_cap:
    assert property (fe_start && !$past(auto_mode) |->
      fe_range_wb == (($past(man_rng) > `TOP_WB) ? `TOP_WB : $past(man_rng)))
    else $error("manual wideband range not capped");
  a_report_shift:
    assert property (report |-> res_vis.shift == $past(fe_range_vis)
                              && res_wb.shift == $past(fe_range_wb))
    else $error("reported shift differs from range used");
  a_split_fields:
    assert property (report |-> res_vis.upper == $past(fe_vis.value[19:8])
                              && res_vis.lower == $past(fe_vis.value[7:0]))
    else $error("result fields split wrong");
  a_linear_code:
    assert property (report |->
      lin_vis == ({8'h00, $past(fe_vis.value)} << $past(fe_range_vis)))
    else $error("linear code wrong");
  a_overflow_retry:
    assert property (conv_end && auto_mode && fe_vis.over && fe_range_vis < `TOP_VIS
      |=> fe_start && !report && fe_range_vis == $past(fe_range_vis) + 4'h1)
    else $error("overflow not retried one range up");
  a_step_up_one:
    assert property (rep_now && auto_mode && fe_vis.value >= `HIGH_LIMIT
      && fe_range_vis < `TOP_VIS |=> fe_range_vis == $past(fe_range_vis) + 4'h1)
    else $error("auto range not raised by one");
  a_step_down:
    assert property (rep_now && auto_mode && fe_vis.value < `LOW1_LIMIT
      && fe_range_vis >= 4'h2 |=> fe_range_vis < $past(fe_range_vis)
      && fe_range_vis + 4'h2 >= $past(fe_range_vis))
    else $error("auto range not lowered by one or two");
  a_flag_needs_run:
    assert property ($rose(flag_h) |-> hi_cnt >= fault_need($past(cfg.fault_count)))
    else $error("high flag set before run complete");
  a_run_restart:
    assert property (rep_now && !hi_now |=> hi_cnt == 4'h0)
    else $error("high run not restarted");
  a_hyst_hold:
    assert property (rep_now && !cfg.latch && !hi_now && !lo_now && !rd_flags
      |=> $stable(flag_h) && $stable(flag_l))
    else $error("flags moved between thresholds");
  a_latched_hold:
    assert property (cfg.latch && flag_h && !rd_flags && $stable(cfg.latch)
      |=> flag_h)
    else $error("latched flag dropped without read");

  c_overflow_retry: cover property (conv_end && retry_any ##1 fe_start);
  c_flag_high: cover property ($rose(flag_h));
  c_latched_clear: cover property (cfg.latch && flag_h && rd_flags ##1 !flag_h);

endmodule // light_autorange_result_threshold

/* light_frontend_model.sv */
// Behavioural light front end that answers both channel samples
module light_frontend_model
  import light_pkg::*;
(
  input  wire logic [3:0]  range_vis,
  input  wire logic [3:0]  range_wb,
  input  wire logic [27:0] light_vis,
  input  wire logic [27:0] light_wb,
  output sample_s          smp_vis,
  output sample_s          smp_wb
);
  timeunit 1ns;
  timeprecision 100ps;

  // Scale light by the range; saturate and flag overflow
  function automatic sample_s scale(input logic [27:0] l, input logic [3:0] r);
    logic [27:0] v;
    sample_s     s;
    v = l >> r;
    s.over = (v > 28'h00F_FFFF);
    s.value = s.over ? 20'hF_FFFF : v[19:0];
    return s;
  endfunction

  // Samples follow the range held for the conversion
  assign smp_vis = scale(light_vis, range_vis);
  assign smp_wb  = scale(light_wb, range_wb);
endmodule // light_frontend_model

/* light_autorange_result_threshold_bench.sv */
// Self-checking bench for range control, result packing and flags
`include "light_cfg.svh"

module light_autorange_result_threshold_bench
  import light_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [27:0] lt = 28'h009_ABCD;

  logic        aclk = '0;
  logic        aresetn = '0;
  logic [7:0]  awaddr = '0;
  logic [7:0]  araddr = '0;
  logic        awvalid = '0;
  logic        wvalid = '0;
  logic        bready = '0;
  logic        arvalid = '0;
  logic        rready = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic [27:0] light_vis = '0;
  logic [27:0] light_wb = '0;
  logic        awready, wready, bvalid, arready, rvalid, fe_start;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd_v;
  logic [3:0]  fe_range_vis, fe_range_wb, sv, sw;
  sample_s     fe_vis, fe_wb;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // Clock and hang guard
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  light_autorange_result_threshold #(
    .conv_cycles('{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15})
  ) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .fe_vis(fe_vis),
    .fe_wb(fe_wb), .fe_start(fe_start), .fe_range_vis(fe_range_vis),
    .fe_range_wb(fe_range_wb)
  );

  light_frontend_model fe_u (
    .range_vis(fe_range_vis), .range_wb(fe_range_wb), .light_vis(light_vis),
    .light_wb(light_wb), .smp_vis(fe_vis), .smp_wb(fe_wb)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        ad = 1;
      if (wready)
        wd = 1;
      if (ad)
        awvalid <= 1'b0;
      if (wd)
        wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check($sformatf("reg %h", a), exp, d);
  endtask

  task automatic wait_starts(input int k);
    repeat (k)
      do @(posedge aclk); while (fe_start !== 1'b1);
  endtask

  // Cycles from one conversion start to the next
  task automatic period_chk(input int want);
    int n;
    n = 0;
    wait_starts(1);
    do
    begin
      @(posedge aclk);
      n++;
    end while (fe_start !== 1'b1);
    check("conv period", 32'(want), 32'(n));
  endtask

  function automatic logic [31:0] res_e(input logic [19:0] v, input logic [3:0] s);
    return {v, 8'h00, s};
  endfunction

  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`OFS_CONFIG, `CONFIG_RESET);
    rchk(`OFS_TH_HIGH, `TH_HIGH_RESET);
    rchk(`OFS_TH_LOW, `TH_LOW_RESET);
    rd(8'h20, rd_v, rs);
    check("unmapped resp", 32'(`RESP_SLVERR), 32'(rs));
    check("unmapped data", 32'h0000_0000, rd_v);
    wr(`OFS_FLAGS, 32'h0000_0003, rs);
    check("ro write resp", 32'(`RESP_OKAY), 32'(rs));
    rchk(`OFS_FLAGS, 32'h0000_0000);
    $display("test reset_map done");

    light_vis <= lt;
    light_wb <= lt;
    for (int m = 0; m <= 8; m++)
    begin
      wr(`OFS_CONFIG, 32'h0000_0800 + 32'(m), rs);
      wait_starts(3);
      sv = 4'(m);
      sw = (m > 6) ? 4'h6 : 4'(m);
      rchk(`OFS_RES_VIS, res_e(20'(lt >> sv), sv));
      rchk(`OFS_RES_WB, res_e(20'(lt >> sw), sw));
      rchk(`OFS_LIN_VIS, 32'((lt >> sv) << sv));
      check("range_vis", 32'(sv), 32'(fe_range_vis));
    end
    period_chk(4);
    $display("test manual done");

    light_vis <= 28'h078_0000;
    light_wb <= 28'h00F_0000;
    wr(`OFS_CONFIG, 32'h0000_080C, rs);
    wait_starts(14);
    rchk(`OFS_RES_VIS, res_e(20'h7_8000, 4'h4));
    rchk(`OFS_RES_WB, res_e(20'h7_8000, 4'h1));
    wait_starts(1);
    light_vis <= 28'h780_0000;
    wait_starts(2);
    check("retry range", 32'h0000_0006, 32'(fe_range_vis));
    check("retry wb", 32'h0000_0001, 32'(fe_range_wb));
    rchk(`OFS_RES_VIS, res_e(20'h7_8000, 4'h4));
    wait_starts(4);
    rchk(`OFS_RES_VIS, res_e(20'h7_8000, 4'h8));
    wait_starts(1);
    light_vis <= 28'h078_0000;
    wait_starts(1);
    check("down two", 32'h0000_0006, 32'(fe_range_vis));
    wait_starts(1);
    check("down two again", 32'h0000_0004, 32'(fe_range_vis));
    light_vis <= 28'h0F0_0000;
    wait_starts(1);
    check("up one", 32'h0000_0005, 32'(fe_range_vis));
    wait_starts(2);
    check("up one only", 32'h0000_0005, 32'(fe_range_vis));
    $display("test auto done");

    light_vis <= 28'h000_5000;
    wr(`OFS_TH_HIGH, 32'h0000_14D5, rs);
    wr(`OFS_TH_LOW, 32'h0000_0001, rs);
    wr(`OFS_CONFIG, 32'h0000_0C30, rs);
    period_chk(7);
    wait_starts(2);
    light_vis <= lt;
    wait_starts(3);
    rchk(`OFS_FLAGS, 32'h0000_0000);
    wait_starts(1);
    rchk(`OFS_FLAGS, 32'h0000_0001);
    light_vis <= 28'h000_5000;
    wait_starts(3);
    rchk(`OFS_FLAGS, 32'h0000_0001);
    light_vis <= 28'h000_0080;
    wait_starts(3);
    light_vis <= 28'h000_5000;
    wait_starts(1);
    light_vis <= 28'h000_0080;
    wait_starts(3);
    rchk(`OFS_FLAGS, 32'h0000_0001);
    wait_starts(1);
    rchk(`OFS_FLAGS, 32'h0000_0002);
    $display("test hysteresis done");

    light_vis <= 28'h000_5000;
    wr(`OFS_CONFIG, 32'h0000_0930, rs);
    wait_starts(2);
    rd(`OFS_FLAGS, rd_v, rs);
    wait_starts(1);
    light_vis <= lt;
    wait_starts(1);
    light_vis <= 28'h000_5000;
    wait_starts(2);
    rchk(`OFS_FLAGS, 32'h0000_0001);
    rchk(`OFS_FLAGS, 32'h0000_0000);
    $display("test latched done");
    wrap_up();
  end
endmodule // light_autorange_result_threshold_bench
